// *** core/flash_poll_ctrl.sv ***
// host sequencer: status polling, hardware reset and deep power-down for a NOR flash
`timescale 1ns/1ps
`include "flash_poll_defs.svh"
// Behaviour
// - data bit 7 equals inverted written bit: pass
// - timeout set on mismatch: reread, mismatch fails
// - poll at program address or erasing sector
// - buffer programming polls last written address
// - buffer abort set on mismatch: reread, abort
// - toggle method reads low byte twice, compares
// - timeout during toggling: read pair again
// - algorithm reset: 10 us low, 20 us ready
// - reset outside algorithm: 500 ns, 500 ns ready
// - wait 200 ns after reset release
// - 50 ns after ready before write strobe (the power-down release write does not wait for ready)
// - power-down release needs 200 us
module flash_poll_ctrl #(
	parameter int unsigned DPD_EXIT_CYC = `T_RDP_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// poll command
	input wire logic poll_start_in,
	input wire flash_poll_pkg::poll_mode_t poll_mode_in,
	input wire flash_poll_pkg::addr_t poll_addr_in,
	input wire logic written_d7_in,
	// write command
	input wire logic write_start_in,
	input wire flash_poll_pkg::write_kind_t write_kind_in,
	input wire flash_poll_pkg::addr_t write_addr_in,
	input wire flash_poll_pkg::data_t write_data_in,
	// hardware reset command
	input wire logic reset_start_in,
	input wire logic reset_in_algo_in,
	// status
	output logic busy_out,
	output logic outcome_valid_out,
	output flash_poll_pkg::outcome_t outcome_out,
	output logic power_down_out,
	// flash pins
	output flash_poll_pkg::addr_t flash_addr_out,
	output logic flash_ce_n_out,
	output logic flash_oe_n_out,
	output logic write_strobe_bar_out,
	output logic flash_reset_n_out,
	output flash_poll_pkg::data_t flash_dq_out,
	output logic flash_dq_oe_out,
	input wire flash_poll_pkg::data_t flash_dq_in,
	input wire logic ready_busy_in
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_POLL_RD = 4'h1,
		ST_RECHECK = 4'h2,
		ST_TOG_A = 4'h3,
		ST_TOG_B = 4'h4,
		ST_TOG_C = 4'h5,
		ST_TOG_D = 4'h6,
		ST_WR_RDY = 4'h7,
		ST_WR_CYC = 4'h8,
		ST_DPD_WAIT = 4'h9,
		ST_RST = 4'hA
	} state_t;

	function automatic flash_poll_pkg::cnt_t max_cnt(input int a, input int b);
		max_cnt = (a > b) ? `CNT_W'(a) : `CNT_W'(b);
	endfunction

	localparam flash_poll_pkg::cnt_t ONE = `CNT_W'(1);
	localparam flash_poll_pkg::cnt_t RB_WE_CYC = `CNT_W'(`T_RB_WE_CYC);
	localparam flash_poll_pkg::cnt_t BUSY_CYC = `CNT_W'(`T_BUSY_CYC);
	localparam flash_poll_pkg::cnt_t DP_CYC = `CNT_W'(`T_DP_CYC);
	localparam flash_poll_pkg::cnt_t RDP_CYC = `CNT_W'(DPD_EXIT_CYC);
	localparam flash_poll_pkg::cnt_t RP1_CYC = `CNT_W'(`T_RP1_CYC);
	localparam flash_poll_pkg::cnt_t RP2_CYC = `CNT_W'(`T_RP2_CYC);
	localparam flash_poll_pkg::cnt_t RST1_TOTAL = max_cnt(`T_READY1_CYC, `T_RP1_CYC + `T_RH_CYC);
	localparam flash_poll_pkg::cnt_t RST2_TOTAL = max_cnt(`T_READY2_CYC, `T_RP2_CYC + `T_RH_CYC);

	bus_cycle_if cyc ();

	state_t state_reg;
	flash_poll_pkg::cnt_t cnt_reg;
	flash_poll_pkg::cnt_t target_reg;
	flash_poll_pkg::cnt_t rst_pulse_reg;
	flash_poll_pkg::cnt_t rdy_cnt_reg;
	flash_poll_pkg::cnt_t hold_cnt_reg;
	flash_poll_pkg::addr_t poll_addr_reg;
	flash_poll_pkg::addr_t last_wr_addr_reg;
	flash_poll_pkg::data_t wr_data_reg;
	flash_poll_pkg::write_kind_t wr_kind_reg;
	logic [7:0] first_rd_reg;
	logic exp7_reg;
	logic buf_mode_reg;
	logic chk_abort_reg;
	logic rdy_meta_reg;
	logic rdy_sync_reg;
	logic needs_cycle;
	logic d7_match;
	logic toggling;
	logic start_hold;

	// ==========================================================
	// pin engine
	flash_bus_cycle u_cycle (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cyc(cyc.engine),
		.addr_out(flash_addr_out),
		.ce_n_out(flash_ce_n_out),
		.oe_n_out(flash_oe_n_out),
		.write_strobe_bar_out(write_strobe_bar_out),
		.dq_out(flash_dq_out),
		.dq_oe_out(flash_dq_oe_out),
		.dq_in(flash_dq_in)
	);

	// ==========================================================
	// status decode
	always_comb begin
		needs_cycle = (state_reg == ST_POLL_RD) || (state_reg == ST_RECHECK) ||
			(state_reg == ST_TOG_A) || (state_reg == ST_TOG_B) ||
			(state_reg == ST_TOG_C) || (state_reg == ST_TOG_D) ||
			(state_reg == ST_WR_CYC);
		d7_match = (cyc.rdata[`DATA_POLL_BIT] == ~exp7_reg);
		toggling = (cyc.rdata[`TOGGLE_FLAG_BIT] != first_rd_reg[`TOGGLE_FLAG_BIT]);
		start_hold = (state_reg == ST_WR_CYC) && cyc.done && (wr_kind_reg == flash_poll_pkg::WK_START_OP);
	end

	// ==========================================================
	// ready/busy synchroniser and ready age
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdy_meta_reg <= 1'b0;
			rdy_sync_reg <= 1'b0;
		end else begin
			rdy_meta_reg <= ready_busy_in;
			rdy_sync_reg <= rdy_meta_reg;
		end
	end

	// the pin is not trusted until the device has had time to show busy
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hold_cnt_reg <= '0;
			rdy_cnt_reg <= '0;
		end else begin
			if (start_hold) begin
				hold_cnt_reg <= BUSY_CYC;
			end else if (hold_cnt_reg != '0) begin
				hold_cnt_reg <= hold_cnt_reg - ONE;
			end
			if (start_hold || hold_cnt_reg != '0 || !rdy_sync_reg) begin
				rdy_cnt_reg <= '0;
			end else if (rdy_cnt_reg < RB_WE_CYC) begin
				rdy_cnt_reg <= rdy_cnt_reg + ONE;
			end
		end
	end

	// ==========================================================
	// cycle requests to the pin engine
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cyc.req <= 1'b0;
			cyc.wr <= 1'b0;
			cyc.addr <= '0;
			cyc.wdata <= '0;
		end else begin
			// dropping req for the done cycle keeps one request per cycle
			cyc.req <= needs_cycle && !cyc.done;
			cyc.wr <= (state_reg == ST_WR_CYC);
			cyc.addr <= (state_reg == ST_WR_CYC) ? last_wr_addr_reg : poll_addr_reg;
			cyc.wdata <= wr_data_reg;
		end
	end

	// ==========================================================
	// command latches
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			poll_addr_reg <= '0;
			last_wr_addr_reg <= '0;
			wr_data_reg <= '0;
			wr_kind_reg <= flash_poll_pkg::WK_PLAIN;
			exp7_reg <= 1'b0;
			buf_mode_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && !reset_start_in) begin
			if (write_start_in) begin
				last_wr_addr_reg <= write_addr_in;
				wr_data_reg <= write_data_in;
				wr_kind_reg <= write_kind_in;
			end else if (poll_start_in) begin
				exp7_reg <= written_d7_in;
				buf_mode_reg <= (poll_mode_in == flash_poll_pkg::PM_BUFFER);
				if (poll_mode_in == flash_poll_pkg::PM_BUFFER) begin
					poll_addr_reg <= last_wr_addr_reg;
				end else begin
					poll_addr_reg <= poll_addr_in;
				end
			end
		end
	end

	// ==========================================================
	// main sequencer
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			target_reg <= '0;
			rst_pulse_reg <= '0;
			first_rd_reg <= '0;
			chk_abort_reg <= 1'b0;
			busy_out <= 1'b0;
			outcome_valid_out <= 1'b0;
			outcome_out <= flash_poll_pkg::OC_NONE;
			power_down_out <= 1'b0;
			flash_reset_n_out <= 1'b1;
		end else begin
			outcome_valid_out <= 1'b0;
			if (reset_start_in && state_reg != ST_RST) begin
				// reset may cut into any sequence except a reset already running; a pending pin cycle just runs out
				flash_reset_n_out <= 1'b0;
				cnt_reg <= '0;
				rst_pulse_reg <= reset_in_algo_in ? RP1_CYC : RP2_CYC;
				target_reg <= reset_in_algo_in ? RST1_TOTAL : RST2_TOTAL;
				busy_out <= 1'b1;
				state_reg <= ST_RST;
			end else begin
				unique case (state_reg)
					ST_IDLE: begin
						if (write_start_in) begin
							busy_out <= 1'b1;
							state_reg <= ST_WR_RDY;
						end else if (poll_start_in && !power_down_out &&
								poll_mode_in != 2'h3) begin
							busy_out <= 1'b1;
							outcome_out <= flash_poll_pkg::OC_NONE;
							state_reg <= (poll_mode_in == flash_poll_pkg::PM_TOGGLE) ?
								ST_TOG_A : ST_POLL_RD;
						end
					end
					ST_POLL_RD: begin
						if (cyc.done) begin
							if (d7_match) begin
								outcome_out <= flash_poll_pkg::OC_PASS;
								outcome_valid_out <= 1'b1;
								busy_out <= 1'b0;
								state_reg <= ST_IDLE;
							end else if (buf_mode_reg && cyc.rdata[`BUFFER_ABORT_BIT]) begin
								chk_abort_reg <= 1'b1;
								state_reg <= ST_RECHECK;
							end else if (cyc.rdata[`TIMEOUT_FLAG_BIT]) begin
								chk_abort_reg <= 1'b0;
								state_reg <= ST_RECHECK;
							end
						end
					end
					ST_RECHECK: begin
						// bit 7 may flip together with the flag, so the reread decides
						if (cyc.done) begin
							if (d7_match) begin
								outcome_out <= flash_poll_pkg::OC_PASS;
							end else if (chk_abort_reg) begin
								outcome_out <= flash_poll_pkg::OC_ABORT;
							end else begin
								outcome_out <= flash_poll_pkg::OC_FAIL;
							end
							outcome_valid_out <= 1'b1;
							busy_out <= 1'b0;
							state_reg <= ST_IDLE;
						end
					end
					ST_TOG_A, ST_TOG_C: begin
						if (cyc.done) begin
							first_rd_reg <= cyc.rdata[7:0];
							state_reg <= (state_reg == ST_TOG_A) ? ST_TOG_B : ST_TOG_D;
						end
					end
					ST_TOG_B: begin
						if (cyc.done) begin
							if (!toggling) begin
								outcome_out <= flash_poll_pkg::OC_PASS;
								outcome_valid_out <= 1'b1;
								busy_out <= 1'b0;
								state_reg <= ST_IDLE;
							end else if (cyc.rdata[`TIMEOUT_FLAG_BIT]) begin
								state_reg <= ST_TOG_C;
							end else begin
								state_reg <= ST_TOG_A;
							end
						end
					end
					ST_TOG_D: begin
						if (cyc.done) begin
							outcome_out <= toggling ? flash_poll_pkg::OC_FAIL :
								flash_poll_pkg::OC_PASS;
							outcome_valid_out <= 1'b1;
							busy_out <= 1'b0;
							state_reg <= ST_IDLE;
						end
					end
					ST_WR_RDY: begin
						// release from power-down cannot wait on the pin
						if (rdy_cnt_reg >= RB_WE_CYC ||
								wr_kind_reg == flash_poll_pkg::WK_DPD_EXIT) begin
							state_reg <= ST_WR_CYC;
						end
					end
					ST_WR_CYC: begin
						if (cyc.done) begin
							cnt_reg <= '0;
							if (wr_kind_reg == flash_poll_pkg::WK_DPD_ENTER) begin
								target_reg <= DP_CYC;
								state_reg <= ST_DPD_WAIT;
							end else if (wr_kind_reg == flash_poll_pkg::WK_DPD_EXIT) begin
								target_reg <= RDP_CYC;
								state_reg <= ST_DPD_WAIT;
							end else begin
								busy_out <= 1'b0;
								state_reg <= ST_IDLE;
							end
						end
					end
					ST_DPD_WAIT: begin
						cnt_reg <= cnt_reg + ONE;
						if (cnt_reg == target_reg - ONE) begin
							power_down_out <= (wr_kind_reg == flash_poll_pkg::WK_DPD_ENTER);
							busy_out <= 1'b0;
							state_reg <= ST_IDLE;
						end
					end
					ST_RST: begin
						cnt_reg <= cnt_reg + ONE;
						if (cnt_reg == rst_pulse_reg - ONE) begin
							flash_reset_n_out <= 1'b1;
						end
						if (cnt_reg == target_reg - ONE) begin
							power_down_out <= 1'b0;
							busy_out <= 1'b0;
							state_reg <= ST_IDLE;
						end
					end
					default: begin
						busy_out <= 1'b0;
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// *** core/flash_poll_defs.svh ***
// timing counts, bit positions and widths for the flash status poller
`ifndef FLASH_POLL_DEFS_SVH
`define FLASH_POLL_DEFS_SVH

// ==========================================================
// widths and status bit positions
`define ADDR_W 24
`define DATA_W 16
`define CNT_W 16
`define DATA_POLL_BIT 7
`define TOGGLE_FLAG_BIT 6
`define TIMEOUT_FLAG_BIT 5
`define BUFFER_ABORT_BIT 1

// ==========================================================
// clock and conversions
`define CLK_NS 10
`define CYC_UP(ns) ((((ns) + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 : (((ns) + `CLK_NS - 1) / `CLK_NS))
`define CYC_DN(ns) (((ns) / `CLK_NS) < 1 ? 1 : ((ns) / `CLK_NS))

// ==========================================================
// pin cycle timing
`define T_ACC_NS 110
`define T_ACC_CYC `CYC_UP(`T_ACC_NS)
`define SYNC_CYC 2
`define T_WP_NS 35
`define T_WP_CYC `CYC_UP(`T_WP_NS)
`define T_WPH_NS 30
`define T_WPH_CYC `CYC_UP(`T_WPH_NS)
`define T_DF_NS 20
`define T_DF_CYC `CYC_UP(`T_DF_NS)

// ==========================================================
// reset, ready/busy and deep power-down timing
`define T_RP1_US 10
`define T_RP1_CYC `CYC_UP(`T_RP1_US * 1000)
`define T_RP2_NS 500
`define T_RP2_CYC `CYC_UP(`T_RP2_NS)
`define T_READY1_US 20
`define T_READY1_CYC `CYC_DN(`T_READY1_US * 1000)
`define T_READY2_NS 500
`define T_READY2_CYC `CYC_DN(`T_READY2_NS)
`define T_RH_NS 200
`define T_RH_CYC `CYC_UP(`T_RH_NS)
`define T_RB_WE_NS 50
`define T_RB_WE_CYC `CYC_UP(`T_RB_WE_NS)
`define T_BUSY_NS 100
`define T_BUSY_CYC `CYC_DN(`T_BUSY_NS)
`define T_DP_US 20
`define T_DP_CYC `CYC_DN(`T_DP_US * 1000)
`define T_RDP_US 200
`define T_RDP_CYC `CYC_DN(`T_RDP_US * 1000)

`endif

// *** core/flash_poll_pkg.sv ***
// types shared by the flash status poller
`include "flash_poll_defs.svh"
package flash_poll_pkg;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef logic [`DATA_W-1:0] data_t;
	typedef logic [`CNT_W-1:0] cnt_t;
	typedef enum logic [1:0] {
		PM_DATA = 2'h0, PM_BUFFER = 2'h1, PM_TOGGLE = 2'h2
	} poll_mode_t;
	typedef enum logic [1:0] {
		WK_PLAIN = 2'h0, WK_START_OP = 2'h1, WK_DPD_ENTER = 2'h2, WK_DPD_EXIT = 2'h3
	} write_kind_t;
	typedef enum logic [1:0] {
		OC_NONE = 2'h0, OC_PASS = 2'h1, OC_FAIL = 2'h2, OC_ABORT = 2'h3
	} outcome_t;
endpackage

// *** core/bus_cycle_if.sv ***
// one read or write cycle request between sequencer and pin engine
`timescale 1ns/1ps
`include "flash_poll_defs.svh"
interface bus_cycle_if;
	logic req;
	logic wr;
	flash_poll_pkg::addr_t addr;
	flash_poll_pkg::data_t wdata;
	logic done;
	flash_poll_pkg::data_t rdata;
	modport master (output req, output wr, output addr, output wdata, input done, input rdata);
	modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// *** core/flash_bus_cycle.sv ***
// pin engine: one asynchronous read or write cycle on the flash bus
`timescale 1ns/1ps
`include "flash_poll_defs.svh"
module flash_bus_cycle (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// request side
	bus_cycle_if.engine cyc,
	// flash pins
	output flash_poll_pkg::addr_t addr_out,
	output logic ce_n_out,
	output logic oe_n_out,
	output logic write_strobe_bar_out,
	output flash_poll_pkg::data_t dq_out,
	output logic dq_oe_out,
	input wire flash_poll_pkg::data_t dq_in
);
	typedef enum logic [2:0] {
		E_IDLE = 3'h0, E_READ = 3'h1, E_WRITE = 3'h2, E_WHOLD = 3'h3, E_GAP = 3'h4
	} eng_state_t;

	function automatic flash_poll_pkg::cnt_t max_cnt(input int a, input int b);
		max_cnt = (a > b) ? `CNT_W'(a) : `CNT_W'(b);
	endfunction

	// sampling waits out the access time plus the synchroniser depth
	localparam flash_poll_pkg::cnt_t READ_CYC = `CNT_W'(`T_ACC_CYC + `SYNC_CYC);
	localparam flash_poll_pkg::cnt_t WP_CYC = `CNT_W'(`T_WP_CYC);
	// one gap serves write-high time and bus float before the next drive
	localparam flash_poll_pkg::cnt_t GAP_CYC = max_cnt(`T_WPH_CYC, `T_DF_CYC);
	localparam flash_poll_pkg::cnt_t ONE = `CNT_W'(1);

	eng_state_t state_reg;
	flash_poll_pkg::cnt_t cnt_reg;
	flash_poll_pkg::data_t dq_meta_reg;
	flash_poll_pkg::data_t dq_sync_reg;

	// ==========================================================
	// data input synchroniser
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dq_meta_reg <= '0;
			dq_sync_reg <= '0;
		end else begin
			dq_meta_reg <= dq_in;
			dq_sync_reg <= dq_meta_reg;
		end
	end

	// ==========================================================
	// cycle sequencer
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= E_IDLE;
			cnt_reg <= '0;
			addr_out <= '0;
			ce_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			write_strobe_bar_out <= 1'b1;
			dq_out <= '0;
			dq_oe_out <= 1'b0;
			cyc.done <= 1'b0;
			cyc.rdata <= '0;
		end else begin
			cyc.done <= 1'b0;
			unique case (state_reg)
				E_IDLE: begin
					if (cyc.req) begin
						addr_out <= cyc.addr;
						ce_n_out <= 1'b0;
						if (cyc.wr) begin
							dq_out <= cyc.wdata;
							dq_oe_out <= 1'b1;
							write_strobe_bar_out <= 1'b0;
							cnt_reg <= WP_CYC - ONE;
							state_reg <= E_WRITE;
						end else begin
							oe_n_out <= 1'b0;
							cnt_reg <= READ_CYC - ONE;
							state_reg <= E_READ;
						end
					end
				end
				E_READ: begin
					if (cnt_reg == '0) begin
						cyc.rdata <= dq_sync_reg;
						cyc.done <= 1'b1;
						ce_n_out <= 1'b1;
						oe_n_out <= 1'b1;
						cnt_reg <= GAP_CYC - ONE;
						state_reg <= E_GAP;
					end else begin
						cnt_reg <= cnt_reg - ONE;
					end
				end
				E_WRITE: begin
					if (cnt_reg == '0) begin
						write_strobe_bar_out <= 1'b1;
						state_reg <= E_WHOLD;
					end else begin
						cnt_reg <= cnt_reg - ONE;
					end
				end
				E_WHOLD: begin
					// address and data held one cycle past the strobe rise
					ce_n_out <= 1'b1;
					dq_oe_out <= 1'b0;
					cyc.done <= 1'b1;
					cnt_reg <= GAP_CYC - ONE;
					state_reg <= E_GAP;
				end
				E_GAP: begin
					if (cnt_reg == '0) begin
						state_reg <= E_IDLE;
					end else begin
						cnt_reg <= cnt_reg - ONE;
					end
				end
				default: begin
					state_reg <= E_IDLE;
				end
			endcase
		end
	end
endmodule

// *** sim/flash_poll_chk.sv ***
// assertions on the ports of the flash status poller
`timescale 1ns/1ps
module flash_poll_chk #(
	parameter int unsigned DPD_EXIT_CYC = 20
) (
	// clock, reset and commands
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic poll_start_in,
	input wire flash_poll_pkg::poll_mode_t poll_mode_in,
	input wire logic write_start_in,
	input wire logic reset_start_in,
	// status and pins
	input wire logic busy_out,
	input wire logic outcome_valid_out,
	input wire flash_poll_pkg::outcome_t outcome_out,
	input wire logic power_down_out,
	input wire logic flash_ce_n_out,
	input wire logic flash_oe_n_out,
	input wire logic write_strobe_bar_out,
	input wire logic flash_reset_n_out,
	input wire logic flash_dq_oe_out,
	input wire logic ready_busy_in
);
	// ==========================================================
	// run-length counters
	int unsigned low_cnt;
	int unsigned high_cnt;
	int unsigned rdy_cnt;
	int unsigned we_cnt;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			low_cnt <= 0;
			high_cnt <= 2000;
			rdy_cnt <= 0;
			we_cnt <= 100000;
		end else begin
			low_cnt <= flash_reset_n_out ? 0 : low_cnt + 1;
			high_cnt <= !flash_reset_n_out ? 0 : (high_cnt < 2000 ? high_cnt + 1 : high_cnt);
			rdy_cnt <= ready_busy_in ? rdy_cnt + 1 : 0;
			we_cnt <= !write_strobe_bar_out ? 0 : (we_cnt < 100000 ? we_cnt + 1 : we_cnt);
		end
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);
	sequence read_low_s;
		!flash_ce_n_out && !flash_oe_n_out;
	endsequence
	sequence read_hold_s;
		read_low_s [*8];
	endsequence
	sequence report_s;
		outcome_out != flash_poll_pkg::OC_NONE && !busy_out ##1 !outcome_valid_out;
	endsequence

	rst_pulse_a: assert property (
		$rose(flash_reset_n_out) |-> low_cnt >= 50) else $error("reset pulse short");
	read_gap_a: assert property (
		$fell(flash_oe_n_out) |-> high_cnt >= 20) else $error("read too soon after reset");
	we_ready_a: assert property (
		$fell(write_strobe_bar_out) && !power_down_out |-> rdy_cnt >= 5)
		else $error("write strobe too soon after ready");
	read_hold_a: assert property (
		$fell(flash_oe_n_out) |-> read_hold_s) else $error("read strobe too short");
	report_once_a: assert property (
		outcome_valid_out |-> report_s) else $error("outcome report malformed");
	poll_take_a: assert property (
		!busy_out && poll_start_in && !write_start_in && !reset_start_in && !power_down_out
		&& poll_mode_in != 2'h3 |=> busy_out && outcome_out == flash_poll_pkg::OC_NONE)
		else $error("poll start not taken");
	dpd_exit_a: assert property (
		$fell(power_down_out) |-> we_cnt >= DPD_EXIT_CYC || high_cnt < 1500)
		else $error("power-down left too early");
	rst_quiet_a: assert property (
		!flash_reset_n_out |-> flash_oe_n_out && write_strobe_bar_out)
		else $error("strobe during reset pulse");
	read_dq_a: assert property (
		!flash_oe_n_out |-> !flash_dq_oe_out) else $error("host drives dq during read");
endmodule

bind flash_poll_ctrl flash_poll_chk #(.DPD_EXIT_CYC(DPD_EXIT_CYC)) u_chk (
	.clk_in(clk_in), .arst_n_in(arst_n_in), .poll_start_in(poll_start_in),
	.poll_mode_in(poll_mode_in), .write_start_in(write_start_in),
	.reset_start_in(reset_start_in), .busy_out(busy_out),
	.outcome_valid_out(outcome_valid_out), .outcome_out(outcome_out),
	.power_down_out(power_down_out), .flash_ce_n_out(flash_ce_n_out),
	.flash_oe_n_out(flash_oe_n_out), .write_strobe_bar_out(write_strobe_bar_out),
	.flash_reset_n_out(flash_reset_n_out), .flash_dq_oe_out(flash_dq_oe_out),
	.ready_busy_in(ready_busy_in));

// *** sim/flash_dev_model.sv ***
// behavioural flash device: status reads, ready/busy, reset and deep power-down
`timescale 1ns/1ps
module flash_dev_model #(
	parameter logic [15:0] CMD_DPD_ENTER = 16'h00D1,
	parameter logic [15:0] CMD_DPD_EXIT = 16'h00D2,
	parameter int T_EXIT_NS = 200000
) (
	// host pins
	input wire logic [23:0] addr_in,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic reset_n_in,
	input wire logic [15:0] dq_in,
	// device pins
	output logic [15:0] dq_out,
	output logic ready_busy_out
);
	// ==========================================================
	// knobs set by the bench per operation
	int busy_reads = 0;
	int reads = 0;
	bit fail_mode = 0;
	bit abort_mode = 0;
	bit wd7 = 0;
	bit dpd = 0;
	logic [23:0] last_addr = 24'h000000;
	logic [15:0] st;
	initial begin
		dq_out = 16'hA5A5;
		ready_busy_out = 1'b1;
	end
	always @(posedge we_n_in) begin
		if (!ce_n_in && dq_in === CMD_DPD_ENTER) begin
			#10000 dpd = 1;
		end else if (!ce_n_in && dq_in === CMD_DPD_EXIT) begin
			#(T_EXIT_NS) dpd = 0;
		end else if (!ce_n_in) begin
			reads = 0;
			#50 ready_busy_out = 1'b0;
		end
	end
	// done toggle level differs from the last busy read, so no early pass
	always @(negedge oe_n_in) begin
		if (!ce_n_in && reset_n_in) begin
			reads = reads + 1;
			last_addr = addr_in;
			st = 16'h0000;
			if (reads > busy_reads && !fail_mode && !abort_mode) begin
				st[7] = !wd7;
				st[6] = !busy_reads[0];
				ready_busy_out = 1'b1;
			end else begin
				st[7] = wd7;
				st[6] = reads[0];
				st[5] = fail_mode && reads > busy_reads;
				st[1] = abort_mode && reads > busy_reads;
			end
			#25 dq_out = st;
		end
	end
	// no pull on dq: a released bus shows the inverse of the last value
	always @(posedge oe_n_in) begin
		#20 dq_out = ~dq_out;
	end
	always @(negedge reset_n_in) begin
		fail_mode = 0;
		abort_mode = 0;
		dpd = 0;
		#500 ready_busy_out = 1'b1;
	end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the flash status poller
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// stimulus, dut and device model
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic poll_start_in = 1'b0;
	flash_poll_pkg::poll_mode_t poll_mode_in = flash_poll_pkg::PM_DATA;
	flash_poll_pkg::addr_t poll_addr_in = 24'h000000;
	logic written_d7_in = 1'b0;
	logic write_start_in = 1'b0;
	flash_poll_pkg::write_kind_t write_kind_in = flash_poll_pkg::WK_PLAIN;
	flash_poll_pkg::addr_t write_addr_in = 24'h000000;
	flash_poll_pkg::data_t write_data_in = 16'h0000;
	logic reset_start_in = 1'b0;
	logic reset_in_algo_in = 1'b0;
	logic busy_out, outcome_valid_out, power_down_out, flash_ce_n_out, flash_oe_n_out;
	logic write_strobe_bar_out, flash_reset_n_out, flash_dq_oe_out, ready_busy_in;
	flash_poll_pkg::outcome_t outcome_out;
	flash_poll_pkg::addr_t flash_addr_out;
	flash_poll_pkg::data_t flash_dq_out, dq_dev, dq_bus;
	int miscompares = 0;
	int cmp_count = 0;
	int seed = 41;
	int exp_q[$];
	assign dq_bus = flash_dq_oe_out ? flash_dq_out : dq_dev;
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	flash_poll_ctrl #(.DPD_EXIT_CYC(20)) u_dut (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .poll_start_in(poll_start_in),
		.poll_mode_in(poll_mode_in), .poll_addr_in(poll_addr_in),
		.written_d7_in(written_d7_in), .write_start_in(write_start_in),
		.write_kind_in(write_kind_in), .write_addr_in(write_addr_in),
		.write_data_in(write_data_in), .reset_start_in(reset_start_in),
		.reset_in_algo_in(reset_in_algo_in), .busy_out(busy_out),
		.outcome_valid_out(outcome_valid_out), .outcome_out(outcome_out),
		.power_down_out(power_down_out), .flash_addr_out(flash_addr_out),
		.flash_ce_n_out(flash_ce_n_out), .flash_oe_n_out(flash_oe_n_out),
		.write_strobe_bar_out(write_strobe_bar_out), .flash_reset_n_out(flash_reset_n_out),
		.flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out),
		.flash_dq_in(dq_bus), .ready_busy_in(ready_busy_in));
	flash_dev_model #(.T_EXIT_NS(150)) u_dev (
		.addr_in(flash_addr_out), .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
		.we_n_in(write_strobe_bar_out), .reset_n_in(flash_reset_n_out), .dq_in(dq_bus),
		.dq_out(dq_dev), .ready_busy_out(ready_busy_in));

	// ==========================================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wait_idle(input int lim, output int n);
		for (n = 0; n < lim && busy_out !== 1'b0; n++) begin
			@(negedge clk_in);
		end
		if (n == lim) begin
			miscompares++;
			end_of_test();
		end
	endtask
	task automatic do_write(input flash_poll_pkg::write_kind_t k, input logic [15:0] d,
		output int n);
		@(posedge clk_in);
		write_kind_in <= k;
		write_data_in <= d;
		write_addr_in <= 24'($random(seed));
		write_start_in <= 1'b1;
		@(posedge clk_in);
		write_start_in <= 1'b0;
		@(negedge clk_in);
		wait_idle(5000, n);
	endtask
	// a short limit marks a poll that is expected to be refused
	task automatic do_poll(input logic [1:0] m, input int lim, output int n);
		@(posedge clk_in);
		poll_mode_in <= flash_poll_pkg::poll_mode_t'(m);
		poll_addr_in <= 24'($random(seed));
		written_d7_in <= u_dev.wd7;
		poll_start_in <= 1'b1;
		@(posedge clk_in);
		poll_start_in <= 1'b0;
		for (n = 0; n < lim && outcome_valid_out !== 1'b1; n++) begin
			@(negedge clk_in);
		end
		if (n == lim && lim > 3) begin
			miscompares++;
			end_of_test();
		end
	endtask
	task automatic do_reset(input logic algo, output int n);
		@(posedge clk_in);
		reset_in_algo_in <= algo;
		reset_start_in <= 1'b1;
		@(posedge clk_in);
		reset_start_in <= 1'b0;
		@(negedge clk_in);
		wait_idle(3000, n);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		int n;
		int md[6] = '{0, 0, 1, 1, 2, 2};
		int fl[6] = '{0, 1, 0, 0, 0, 1};
		int ab[6] = '{0, 0, 0, 1, 0, 0};
		logic [23:0] wa;
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'b1;
		do_reset(1'b0, n);
		check(n >= 69, 1);
		check(flash_reset_n_out, 1);
		for (int i = 0; i < 6; i++) begin
			u_dev.busy_reads = $unsigned($random(seed)) % 5;
			u_dev.fail_mode = fl[i];
			u_dev.abort_mode = ab[i];
			u_dev.wd7 = $random(seed);
			exp_q.push_back(ab[i] ? 3 : (fl[i] ? 2 : 1));
			do_write(flash_poll_pkg::WK_START_OP, 16'h0030, n);
			wa = write_addr_in;
			do_poll(md[i][1:0], 20000, n);
			check(outcome_out, exp_q.pop_front());
			check(busy_out, 0);
			if (md[i] == 1) check(u_dev.last_addr, wa);
			else check(u_dev.last_addr, poll_addr_in);
			if (md[i] < 2) check(u_dev.reads, u_dev.busy_reads + 1 + (fl[i] | ab[i]));
			if (fl[i] | ab[i]) begin
				do_reset(1'b1, n);
				check(n >= 1019, 1);
			end
		end
		do_write(flash_poll_pkg::WK_PLAIN, 16'h00F0, n);
		check(u_dev.reads, 0);
		do_reset(1'b0, n);
		do_poll(2'h3, 3, n);
		check(busy_out, 0);
		do_write(flash_poll_pkg::WK_DPD_ENTER, 16'h00D1, n);
		check(power_down_out, 1);
		check(u_dev.dpd, 1);
		do_poll(2'h0, 3, n);
		check(busy_out, 0);
		do_write(flash_poll_pkg::WK_DPD_EXIT, 16'h00D2, n);
		check(power_down_out, 0);
		check(u_dev.dpd, 0);
		end_of_test();
	end
endmodule
